// ===== dmaar_defs.svh
// Purpose: Offsets, field positions and reset values of the DMA address registers
// Assumes: Word index = printed offset; byte address on the bus = index * 4
// Notes: Only the low eight bits of each index are decoded inside the block window
`ifndef DMAAR_DEFS_SVH
`define DMAAR_DEFS_SVH

`define DMAAR_IDX_SRC_HI0 32'hFFFFF1A0
`define DMAAR_IDX_SRC_LO0 32'hFFFFF1A2
`define DMAAR_IDX_DST_HI0 32'hFFFFF1A4
`define DMAAR_IDX_DST_LO0 32'hFFFFF1A6
`define DMAAR_IDX_SRC_HI1 32'hFFFFF1A8
`define DMAAR_IDX_SRC_LO1 32'hFFFFF1AA
`define DMAAR_IDX_DST_HI1 32'hFFFFF1AC
`define DMAAR_IDX_DST_LO1 32'hFFFFF1AE
`define DMAAR_IDX_SRC_HI2 32'hFFFFF1B0
`define DMAAR_IDX_SRC_LO2 32'hFFFFF1B2
`define DMAAR_IDX_DST_HI2 32'hFFFFF1B4
`define DMAAR_IDX_DST_LO2 32'hFFFFF1B6
`define DMAAR_IDX_SRC_HI3 32'hFFFFF1B8
`define DMAAR_IDX_SRC_LO3 32'hFFFFF1BA
`define DMAAR_IDX_DST_HI3 32'hFFFFF1BC
`define DMAAR_IDX_DST_LO3 32'hFFFFF1BE
`define DMAAR_IDX_CTRL0 32'hFFFFF1C0
`define DMAAR_IDX_CTRL1 32'hFFFFF1C1
`define DMAAR_IDX_CTRL2 32'hFFFFF1C2
`define DMAAR_IDX_CTRL3 32'hFFFFF1C3

`define DMAAR_IDX_LSB 2
`define DMAAR_IDX_BITS 8
`define DMAAR_ADDR_BITS 26
`define DMAAR_HALF_BITS 16
`define DMAAR_HI_BITS 10
`define DMAAR_CHANNELS 4
`define DMAAR_TRANSFER_TYPE_FIELD_LSB 0
`define DMAAR_TRANSFER_TYPE_FIELD_BITS 2
`define DMAAR_ADDR_RESET 26'h0000000
`define DMAAR_TRANSFER_TYPE_FIELD_RESET 2'h0

`endif

// ===== dmaar_pkg.sv
// Purpose: Types shared by the DMA address register block
// Assumes: Widths are written out here; no macro from dmaar_defs.svh is used
// Notes: None
`include "dmaar_defs.svh"
`default_nettype none
package dmaar_pkg;
   typedef enum logic [2:0] {
      KIND_NONE,
      KIND_SRC_HI,
      KIND_SRC_LO,
      KIND_DST_HI,
      KIND_DST_LO,
      KIND_CTRL
   } dmaar_kind_type;

   typedef enum logic [1:0] {
      TT_TWO_CYCLE,
      TT_FLYBY_EXT,
      TT_FLYBY_INT,
      TT_RESERVED
   } dmaar_transfer_type_field_type;

   typedef enum logic [1:0] {
      STEP_HOLD,
      STEP_INC,
      STEP_DEC,
      STEP_HOLD2
   } dmaar_step_type;

   typedef struct packed {
      logic hit;
      logic [1:0] chan;
      dmaar_kind_type kind;
   } dmaar_dec_type;
endpackage
`default_nettype wire

// ===== dmaar_regbus_if.sv
// Purpose: Register access path between the bus front end and the register file
// Assumes: One clock domain
// Notes: Write strobe and read load are one-cycle pulses
`include "dmaar_defs.svh"
`default_nettype none
interface dmaar_regbus_if;
   logic wr_stb;
   logic [`DMAAR_IDX_BITS-1:0] wr_idx;
   logic [`DMAAR_HALF_BITS-1:0] wr_data;
   logic [`DMAAR_IDX_BITS-1:0] rd_idx;
   logic [`DMAAR_HALF_BITS-1:0] rd_data;

   modport front (output wr_stb, output wr_idx, output wr_data, output rd_idx,
      input rd_data);
   modport regs (input wr_stb, input wr_idx, input wr_data, input rd_idx,
      output rd_data);
endinterface
`default_nettype wire

// ===== dmaar_step.sv
// Purpose: Next-address computation for one 26-bit address pair
// Assumes: Step size is one byte or one halfword
// Notes: Wraps modulo 2**26, as the address lines do
`include "dmaar_defs.svh"
`default_nettype none
module dmaar_step (
   input wire logic [`DMAAR_ADDR_BITS-1:0] cur_addr,
   input wire dmaar_pkg::dmaar_step_type mode,
   input wire logic unit_half,
   output logic [`DMAAR_ADDR_BITS-1:0] next_addr
);
   wire [`DMAAR_ADDR_BITS-1:0] step_amt;
   wire [`DMAAR_ADDR_BITS-1:0] addr_up;
   wire [`DMAAR_ADDR_BITS-1:0] addr_down;

   assign step_amt = unit_half ? 26'h0000002 : 26'h0000001;
   assign addr_up = cur_addr + step_amt;
   assign addr_down = cur_addr - step_amt;

   always_comb begin
      case (mode)
         dmaar_pkg::STEP_INC: next_addr = addr_up;
         dmaar_pkg::STEP_DEC: next_addr = addr_down;
         default: next_addr = cur_addr;
      endcase
   end
endmodule
`default_nettype wire

// ===== dmaar_ahb_fe.sv
// Purpose: AHB-Lite slave front end for the DMA address registers
// Assumes: Single word transfers; the one slave's hreadyout is hready
// Notes: Writes take no wait state; reads take one so the data comes from a flop
`include "dmaar_defs.svh"
`default_nettype none
module dmaar_ahb_fe (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   dmaar_regbus_if.front rbus
);
   typedef enum {ST_IDLE, ST_WRITE, ST_READ_WAIT, ST_READ_DONE} dmaar_fe_state_type;

   dmaar_fe_state_type state_reg, state_next;
   logic [`DMAAR_IDX_BITS-1:0] idx_reg;
   logic [31:0] rdata_reg;
   wire addr_phase;
   wire [`DMAAR_IDX_BITS-1:0] addr_idx;

   // Size is not checked: any width writes the low halfword
   assign addr_phase = hsel & htrans[1] & hready;
   assign addr_idx = haddr[`DMAAR_IDX_LSB +: `DMAAR_IDX_BITS];

   always_comb begin
      state_next = ST_IDLE;
      case (state_reg)
         ST_READ_WAIT: state_next = ST_READ_DONE;
         default: begin
            if (addr_phase) begin
               state_next = hwrite ? ST_WRITE : ST_READ_WAIT;
            end
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg <= ST_IDLE;
         idx_reg <= 8'h00;
         rdata_reg <= 32'h00000000;
      end else begin
         state_reg <= state_next;
         if (addr_phase) begin
            idx_reg <= addr_idx;
         end
         if (state_reg == ST_READ_WAIT) begin
            rdata_reg <= {16'h0000, rbus.rd_data};
         end
      end
   end

   // The wait cycle lets a write just before a read land first
   assign hreadyout = (state_reg != ST_READ_WAIT);
   assign hresp = 1'b0;
   assign hrdata = rdata_reg;
   assign rbus.wr_stb = (state_reg == ST_WRITE);
   assign rbus.wr_idx = idx_reg;
   assign rbus.wr_data = hwdata[`DMAAR_HALF_BITS-1:0];
   assign rbus.rd_idx = idx_reg;
endmodule
`default_nettype wire

// ===== dmaar_top.sv
// Purpose: Source and destination address registers of a four-channel DMA engine
// Assumes: Sequencer inputs are synchronous to hclk; one channel stepped per cycle
// Notes: Unmapped words read zero and ignore writes; every answer is OKAY
//
// The AHB-Lite slave port was left to the implementer.
`include "dmaar_defs.svh"
`default_nettype none
// Overview of operation
// - Four channels each own source/destination registers
// - Low source register holds address bits 15-0
// - Source pair advances to next source address
// - Flyby external: source pair gives memory address
// - Destination address is 26 bits wide
// - Destination split into separately writable halves
// - Destination pair advances to next destination address
// - Flyby external transfer type ignores destination registers
// - Source address 26 bits, high/low halves
// - High source holds bits 25-16, upper zero
module dmaar_top (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [1:0] seq_chan,
   input wire logic seq_src_adv,
   input wire logic seq_dst_adv,
   input wire dmaar_pkg::dmaar_step_type seq_src_mode,
   input wire dmaar_pkg::dmaar_step_type seq_dst_mode,
   input wire logic seq_unit_half,
   output logic [`DMAAR_CHANNELS-1:0][`DMAAR_ADDR_BITS-1:0] src_addr,
   output logic [`DMAAR_CHANNELS-1:0][`DMAAR_ADDR_BITS-1:0] dst_addr,
   output logic [`DMAAR_CHANNELS-1:0][`DMAAR_ADDR_BITS-1:0] mem_addr,
   output logic [`DMAAR_CHANNELS-1:0] dst_used,
   output logic [`DMAAR_CHANNELS-1:0][`DMAAR_TRANSFER_TYPE_FIELD_BITS-1:0] transfer_type_field
);
   localparam int NCH = `DMAAR_CHANNELS;
   localparam int AW = `DMAAR_ADDR_BITS;
   localparam int HW = `DMAAR_HALF_BITS;
   localparam int HIW = `DMAAR_HI_BITS;

   dmaar_regbus_if rbus ();

   // Register storage: one source and one destination pair per channel
   logic [AW-1:0] src_addr_reg [NCH];
   logic [AW-1:0] dst_addr_reg [NCH];
   logic [AW-1:0] src_addr_next [NCH];
   logic [AW-1:0] dst_addr_next [NCH];
   logic [`DMAAR_TRANSFER_TYPE_FIELD_BITS-1:0] transfer_type_field_reg [NCH];
   logic [`DMAAR_TRANSFER_TYPE_FIELD_BITS-1:0] transfer_type_field_next [NCH];

   wire dmaar_pkg::dmaar_dec_type wr_dec;
   wire dmaar_pkg::dmaar_dec_type rd_dec;
   wire [HW-1:0] rd_word;

   // Maps a word index to channel and register kind
   function automatic dmaar_pkg::dmaar_dec_type decode_idx(input logic [7:0] idx);
      dmaar_pkg::dmaar_dec_type d;
      d.hit = 1'b1;
      d.chan = 2'h0;
      d.kind = dmaar_pkg::KIND_NONE;
      case (idx)
         8'(`DMAAR_IDX_SRC_HI0): begin d.chan = 2'h0; d.kind = dmaar_pkg::KIND_SRC_HI; end
         8'(`DMAAR_IDX_SRC_LO0): begin d.chan = 2'h0; d.kind = dmaar_pkg::KIND_SRC_LO; end
         8'(`DMAAR_IDX_DST_HI0): begin d.chan = 2'h0; d.kind = dmaar_pkg::KIND_DST_HI; end
         8'(`DMAAR_IDX_DST_LO0): begin d.chan = 2'h0; d.kind = dmaar_pkg::KIND_DST_LO; end
         8'(`DMAAR_IDX_SRC_HI1): begin d.chan = 2'h1; d.kind = dmaar_pkg::KIND_SRC_HI; end
         8'(`DMAAR_IDX_SRC_LO1): begin d.chan = 2'h1; d.kind = dmaar_pkg::KIND_SRC_LO; end
         8'(`DMAAR_IDX_DST_HI1): begin d.chan = 2'h1; d.kind = dmaar_pkg::KIND_DST_HI; end
         8'(`DMAAR_IDX_DST_LO1): begin d.chan = 2'h1; d.kind = dmaar_pkg::KIND_DST_LO; end
         8'(`DMAAR_IDX_SRC_HI2): begin d.chan = 2'h2; d.kind = dmaar_pkg::KIND_SRC_HI; end
         8'(`DMAAR_IDX_SRC_LO2): begin d.chan = 2'h2; d.kind = dmaar_pkg::KIND_SRC_LO; end
         8'(`DMAAR_IDX_DST_HI2): begin d.chan = 2'h2; d.kind = dmaar_pkg::KIND_DST_HI; end
         8'(`DMAAR_IDX_DST_LO2): begin d.chan = 2'h2; d.kind = dmaar_pkg::KIND_DST_LO; end
         8'(`DMAAR_IDX_SRC_HI3): begin d.chan = 2'h3; d.kind = dmaar_pkg::KIND_SRC_HI; end
         8'(`DMAAR_IDX_SRC_LO3): begin d.chan = 2'h3; d.kind = dmaar_pkg::KIND_SRC_LO; end
         8'(`DMAAR_IDX_DST_HI3): begin d.chan = 2'h3; d.kind = dmaar_pkg::KIND_DST_HI; end
         8'(`DMAAR_IDX_DST_LO3): begin d.chan = 2'h3; d.kind = dmaar_pkg::KIND_DST_LO; end
         8'(`DMAAR_IDX_CTRL0): begin d.chan = 2'h0; d.kind = dmaar_pkg::KIND_CTRL; end
         8'(`DMAAR_IDX_CTRL1): begin d.chan = 2'h1; d.kind = dmaar_pkg::KIND_CTRL; end
         8'(`DMAAR_IDX_CTRL2): begin d.chan = 2'h2; d.kind = dmaar_pkg::KIND_CTRL; end
         8'(`DMAAR_IDX_CTRL3): begin d.chan = 2'h3; d.kind = dmaar_pkg::KIND_CTRL; end
         default: d.hit = 1'b0;
      endcase
      return d;
   endfunction

   dmaar_ahb_fe u_fe (
      .hclk(hclk),
      .hresetn(hresetn),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hwdata(hwdata),
      .hready(hready),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .hrdata(hrdata),
      .rbus(rbus.front)
   );

   assign wr_dec = decode_idx(rbus.wr_idx);
   assign rd_dec = decode_idx(rbus.rd_idx);

   // Read mux: unused high bits read zero
   logic [HW-1:0] rd_word_c;
   always_comb begin
      rd_word_c = 16'h0000;
      if (rd_dec.hit) begin
         case (rd_dec.kind)
            dmaar_pkg::KIND_SRC_HI:
               rd_word_c = {6'h00, src_addr_reg[rd_dec.chan][AW-1:HW]};
            dmaar_pkg::KIND_SRC_LO: rd_word_c = src_addr_reg[rd_dec.chan][HW-1:0];
            dmaar_pkg::KIND_DST_HI:
               rd_word_c = {6'h00, dst_addr_reg[rd_dec.chan][AW-1:HW]};
            dmaar_pkg::KIND_DST_LO: rd_word_c = dst_addr_reg[rd_dec.chan][HW-1:0];
            dmaar_pkg::KIND_CTRL: rd_word_c = {14'h0000, transfer_type_field_reg[rd_dec.chan]};
            default: rd_word_c = 16'h0000;
         endcase
      end
   end
   assign rd_word = rd_word_c;
   assign rbus.rd_data = rd_word;

   genvar ch;
   generate
      for (ch = 0; ch < NCH; ch++) begin : g_chan
         wire sel = (seq_chan == 2'(ch));
         wire flyby_ext = (transfer_type_field_reg[ch] == dmaar_pkg::TT_FLYBY_EXT);
         wire wr_here = rbus.wr_stb & wr_dec.hit & (wr_dec.chan == 2'(ch));
         wire src_step = sel & seq_src_adv;
         // External flyby has no destination access to track
         wire dst_step = sel & seq_dst_adv & ~flyby_ext;
         wire [AW-1:0] src_stepped;
         wire [AW-1:0] dst_stepped;

         dmaar_step u_src_step (
            .cur_addr(src_addr_reg[ch]),
            .mode(seq_src_mode),
            .unit_half(seq_unit_half),
            .next_addr(src_stepped)
         );

         dmaar_step u_dst_step (
            .cur_addr(dst_addr_reg[ch]),
            .mode(seq_dst_mode),
            .unit_half(seq_unit_half),
            .next_addr(dst_stepped)
         );

         // A sequencer step wins over a software write in the same cycle
         always_comb begin
            src_addr_next[ch] = src_addr_reg[ch];
            if (src_step) begin
               src_addr_next[ch] = src_stepped;
            end else if (wr_here && wr_dec.kind == dmaar_pkg::KIND_SRC_HI) begin
               src_addr_next[ch] = {rbus.wr_data[HIW-1:0],
                  src_addr_reg[ch][HW-1:0]};
            end else if (wr_here && wr_dec.kind == dmaar_pkg::KIND_SRC_LO) begin
               src_addr_next[ch] = {src_addr_reg[ch][AW-1:HW], rbus.wr_data};
            end
         end

         always_comb begin
            dst_addr_next[ch] = dst_addr_reg[ch];
            if (dst_step) begin
               dst_addr_next[ch] = dst_stepped;
            end else if (wr_here && wr_dec.kind == dmaar_pkg::KIND_DST_HI) begin
               dst_addr_next[ch] = {rbus.wr_data[HIW-1:0],
                  dst_addr_reg[ch][HW-1:0]};
            end else if (wr_here && wr_dec.kind == dmaar_pkg::KIND_DST_LO) begin
               dst_addr_next[ch] = {dst_addr_reg[ch][AW-1:HW], rbus.wr_data};
            end
         end

         always_comb begin
            transfer_type_field_next[ch] = transfer_type_field_reg[ch];
            if (wr_here && wr_dec.kind == dmaar_pkg::KIND_CTRL) begin
               transfer_type_field_next[ch] = rbus.wr_data[`DMAAR_TRANSFER_TYPE_FIELD_LSB +: `DMAAR_TRANSFER_TYPE_FIELD_BITS];
            end
         end

         // Reset loads zero into both address pairs and the transfer type field
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               src_addr_reg[ch] <= `DMAAR_ADDR_RESET;
               dst_addr_reg[ch] <= `DMAAR_ADDR_RESET;
               transfer_type_field_reg[ch] <= `DMAAR_TRANSFER_TYPE_FIELD_RESET;
            end else begin
               src_addr_reg[ch] <= src_addr_next[ch];
               dst_addr_reg[ch] <= dst_addr_next[ch];
               transfer_type_field_reg[ch] <= transfer_type_field_next[ch];
            end
         end

         assign src_addr[ch] = src_addr_reg[ch];
         assign dst_addr[ch] = dst_addr_reg[ch];
         // Memory side always comes from the source pair in external flyby
         assign mem_addr[ch] = src_addr_reg[ch];
         // Internal flyby and two-cycle both consume the destination pair
         assign dst_used[ch] = ~flyby_ext;
         assign transfer_type_field[ch] = transfer_type_field_reg[ch];
      end
   endgenerate
endmodule
`default_nettype wire

// ===== dmaar_top_sva.sv
// Purpose: Port-level checks of the DMA address register block
// Assumes: hready is fed back from hreadyout
// Notes: Bus write data phase is tracked so that software writes are not mistaken for steps
`include "dmaar_defs.svh"
`default_nettype none
module dmaar_top_sva (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire logic [1:0] seq_chan,
   input wire logic seq_src_adv,
   input wire logic seq_dst_adv,
   input wire dmaar_pkg::dmaar_step_type seq_src_mode,
   input wire dmaar_pkg::dmaar_step_type seq_dst_mode,
   input wire logic seq_unit_half,
   input wire logic [`DMAAR_CHANNELS-1:0][`DMAAR_ADDR_BITS-1:0] src_addr,
   input wire logic [`DMAAR_CHANNELS-1:0][`DMAAR_ADDR_BITS-1:0] dst_addr,
   input wire logic [`DMAAR_CHANNELS-1:0][`DMAAR_ADDR_BITS-1:0] mem_addr,
   input wire logic [`DMAAR_CHANNELS-1:0] dst_used,
   input wire logic [`DMAAR_CHANNELS-1:0][`DMAAR_TRANSFER_TYPE_FIELD_BITS-1:0] transfer_type_field
);
   logic rd_take;
   logic wr_take;
   logic wr_dp_reg;
   logic [3:0] flyby;
   assign rd_take = hsel & htrans[1] & hready & ~hwrite;
   assign wr_take = hsel & htrans[1] & hready & hwrite;
   assign flyby = {transfer_type_field[3] == 2'h1, transfer_type_field[2] == 2'h1,
      transfer_type_field[1] == 2'h1, transfer_type_field[0] == 2'h1};
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_dp_reg <= 1'b0;
      end else begin
         wr_dp_reg <= wr_take;
      end
   end
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   mem_src_a: assert property (mem_addr == src_addr)
      else $error("memory address differs from source pair");
   dst_flag_a: assert property (dst_used == ~flyby)
      else $error("destination use flag wrong");
   dst_hold_a: assert property (seq_dst_adv && flyby[seq_chan] && !wr_dp_reg |=>
      $stable(dst_addr)) else $error("destination moved in external flyby");
   src_inc_a: assert property (seq_src_adv && seq_src_mode == dmaar_pkg::STEP_INC |=>
      src_addr[$past(seq_chan)] == $past(src_addr[seq_chan]) +
      ($past(seq_unit_half) ? 26'h2 : 26'h1)) else $error("source increment wrong");
   dst_dec_a: assert property (seq_dst_adv && !flyby[seq_chan] &&
      seq_dst_mode == dmaar_pkg::STEP_DEC |=> dst_addr[$past(seq_chan)] ==
      $past(dst_addr[seq_chan]) - ($past(seq_unit_half) ? 26'h2 : 26'h1))
      else $error("destination decrement wrong");
   src_keep_a: assert property (seq_src_adv && !wr_dp_reg &&
      seq_src_mode inside {dmaar_pkg::STEP_HOLD, dmaar_pkg::STEP_HOLD2} |=> $stable(src_addr))
      else $error("source moved on hold step");
   hi_zero_a: assert property (rd_take && haddr[9:7] == 3'h5 && haddr[3:2] == 2'h0 |->
      ##2 hrdata[31:10] == 22'h0) else $error("high half upper bits not zero");
   rd_wait_a: assert property (rd_take |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   wr_fast_a: assert property (wr_take |=> hreadyout) else $error("write stalled");
   okay_resp_a: assert property (hresp == 1'b0) else $error("response not okay");
   cover property (rd_take ##1 !hreadyout ##1 hreadyout);
   cover property (seq_dst_adv && flyby[seq_chan]);
   cover property (seq_src_adv && seq_src_mode == dmaar_pkg::STEP_DEC);
endmodule
bind dmaar_top dmaar_top_sva chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
   .hresp(hresp), .hrdata(hrdata), .seq_chan(seq_chan), .seq_src_adv(seq_src_adv),
   .seq_dst_adv(seq_dst_adv), .seq_src_mode(seq_src_mode), .seq_dst_mode(seq_dst_mode),
   .seq_unit_half(seq_unit_half), .src_addr(src_addr), .dst_addr(dst_addr),
   .mem_addr(mem_addr), .dst_used(dst_used), .transfer_type_field(transfer_type_field));
`default_nettype wire

// ===== dmaar_seq_model.sv
// Purpose: Transfer sequencer model that steps the address pairs
// Assumes: step is called right after a rising edge
// Notes: Channel and unit go to junk between bursts so no stale value is relied on
`default_nettype none
module dmaar_seq_model (
   input wire logic hclk,
   output logic [1:0] seq_chan,
   output logic seq_src_adv,
   output logic seq_dst_adv,
   output var dmaar_pkg::dmaar_step_type seq_src_mode,
   output var dmaar_pkg::dmaar_step_type seq_dst_mode,
   output logic seq_unit_half
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      seq_chan = 2'h0;
      seq_src_adv = 1'b0;
      seq_dst_adv = 1'b0;
      seq_src_mode = dmaar_pkg::STEP_HOLD;
      seq_dst_mode = dmaar_pkg::STEP_HOLD;
      seq_unit_half = 1'b0;
   end
   task automatic step(input logic [1:0] c, input logic s, input logic d,
      input dmaar_pkg::dmaar_step_type m, input logic h, input int n);
      seq_chan <= c;
      seq_src_adv <= s;
      seq_dst_adv <= d;
      seq_src_mode <= m;
      seq_dst_mode <= m;
      seq_unit_half <= h;
      repeat (n) @(posedge hclk);
      seq_src_adv <= 1'b0;
      seq_dst_adv <= 1'b0;
      seq_chan <= ~c;
      seq_unit_half <= ~h;
   endtask
endmodule
`default_nettype wire

// ===== test_dma_channel_address_regs.sv
// Purpose: Self-checking bench for the DMA address register block
// Assumes: One AHB-Lite master; hready fed back from hreadyout
// Notes: A monitor checks read data against a queue of expected words
`include "dmaar_defs.svh"
`default_nettype none
module test_dma_channel_address_regs;
   timeunit 1ns;
   timeprecision 1ns;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, seq_src_adv, seq_dst_adv, seq_unit_half;
   logic [31:0] haddr, hwdata, hrdata;
   logic [2:0] hsize;
   logic [1:0] htrans, seq_chan;
   dmaar_pkg::dmaar_step_type seq_src_mode, seq_dst_mode;
   logic [3:0][25:0] src_addr, dst_addr, mem_addr;
   logic [3:0][1:0] transfer_type_field;
   logic [3:0] dst_used;
   logic [25:0] sm[4] = '{default: 26'h0};
   logic [25:0] dm[4] = '{default: 26'h0};
   logic [1:0] tt[4] = '{default: 2'h0};
   logic [31:0] exp_q[$];
   logic rd_dp = 1'b0;
   int errors = 0;
   int n_tests = 0;
   int seed = 10;
   dmaar_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .seq_chan(seq_chan),
      .seq_src_adv(seq_src_adv), .seq_dst_adv(seq_dst_adv), .seq_src_mode(seq_src_mode),
      .seq_dst_mode(seq_dst_mode), .seq_unit_half(seq_unit_half), .src_addr(src_addr),
      .dst_addr(dst_addr), .mem_addr(mem_addr), .dst_used(dst_used),
      .transfer_type_field(transfer_type_field));
   dmaar_seq_model seqm (.hclk(hclk), .seq_chan(seq_chan), .seq_src_adv(seq_src_adv),
      .seq_dst_adv(seq_dst_adv), .seq_src_mode(seq_src_mode), .seq_dst_mode(seq_dst_mode),
      .seq_unit_half(seq_unit_half));
   initial begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end
   task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: read %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp_out(input logic [25:0] got, input logic [25:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: output %h expected %h", $time, got, exp);
      end
   endtask
   // Sampled at the falling edge, where hreadyout and hrdata have settled
   always @(negedge hclk) begin
      if (rd_dp && hreadyout === 1'b1) begin
         rd_dp = 1'b0;
         cmp_rd(hrdata, exp_q.pop_front());
      end
      if (hsel && htrans[1] && !hwrite && hreadyout) rd_dp = 1'b1;
   end
   task automatic wait_rdy;
      logic r;
      do begin
         @(negedge hclk);
         r = hreadyout;
         @(posedge hclk);
      end while (r !== 1'b1);
   endtask
   task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      haddr <= ~a;
      hwdata <= d;
      wait_rdy();
      hwdata <= ~d;
   endtask
   function automatic logic [31:0] ra(input int c, input int k);
      return (`DMAAR_IDX_SRC_HI0 + 8 * c + 2 * k) << 2;
   endfunction
   task automatic put(input int c, input int k, input logic [31:0] d);
      xfer(1'b1, ra(c, k), d);
      case (k)
         0: sm[c][25:16] = d[9:0];
         1: sm[c][15:0] = d[15:0];
         2: dm[c][25:16] = d[9:0];
         default: dm[c][15:0] = d[15:0];
      endcase
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      xfer(1'b0, a, 32'h0);
   endtask
   task automatic get(input int c, input int k);
      logic [25:0] v;
      v = (k < 2) ? sm[c] : dm[c];
      rd(ra(c, k), k[0] ? {16'h0, v[15:0]} : {22'h0, v[25:16]});
   endtask
   task automatic chk(input int c);
      @(negedge hclk);
      cmp_out(src_addr[c], sm[c]);
      cmp_out(mem_addr[c], sm[c]);
      cmp_out(dst_addr[c], dm[c]);
      cmp_out({24'h0, transfer_type_field[c]}, {24'h0, tt[c]});
      cmp_out({25'h0, dst_used[c]}, {25'h0, tt[c] != 2'h1});
      @(posedge hclk);
   endtask
   function automatic logic [25:0] nx(input logic [25:0] v, input int m, input logic h);
      logic [25:0] u;
      u = h ? 26'h2 : 26'h1;
      return (m == 1) ? v + u : (m == 2) ? v - u : v;
   endfunction
   task automatic stp(input int c, input logic s, input logic d, input int m, input logic h,
      input int n);
      seqm.step(c[1:0], s, d, dmaar_pkg::dmaar_step_type'(m), h, n);
      repeat (n) begin
         if (s) sm[c] = nx(sm[c], m, h);
         if (d && tt[c] != 2'h1) dm[c] = nx(dm[c], m, h);
      end
   endtask
   task automatic wrap_up;
      $display("errors %0d, comparisons %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      #100000;
      errors++;
      wrap_up();
   end
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      for (int c = 0; c < 4; c++) chk(c);
      for (int c = 0; c < 4; c++) begin
         for (int k = 0; k < 4; k++) put(c, k, $random(seed));
      end
      for (int c = 0; c < 4; c++) begin
         for (int k = 0; k < 4; k++) get(c, k);
         chk(c);
      end
      put(0, 1, $random(seed));
      get(0, 0);
      get(0, 1);
      // Unmapped word inside the window: write dropped, read zero
      xfer(1'b1, 32'h284, 32'hFFFF);
      rd(32'h284, 32'h0);
      put(2, 0, 32'h3FF);
      put(2, 1, 32'hFFFF);
      for (int i = 0; i < 8; i++) begin
         stp(i % 4, 1'b1, 1'b1, i / 2, i[0], 1);
         chk(i % 4);
      end
      get(2, 0);
      get(2, 1);
      stp(1, 1'b1, 1'b1, 2, 1'b1, 3);
      chk(1);
      for (int t = 0; t < 4; t++) begin
         if (t == 2) put(3, 3, $random(seed));
         xfer(1'b1, (`DMAAR_IDX_CTRL0 + 3) << 2, 32'(t));
         tt[3] = t[1:0];
         stp(3, 1'b1, 1'b1, 1, 1'b0, 2);
         chk(3);
         get(3, 3);
      end
      wrap_up();
   end
endmodule
`default_nettype wire
